// >>> design/sbio_pkg.sv
// Purpose: shared constants for the serial board I/O expander and its host
// Assumes: mode-0 serial frames, 16 bits per transaction, msb first
// Notes: register map and command framing are local choices
//
// Functional notes
// - gpio read: outputs give driven, inputs pins
// - three gpio banks, each data and direction
// - written data drives output pins only
// - host masters link, expander is slave
// - read: address out, eight data bits back
// - write: address byte then data byte
// - led register sets and returns led pattern
// - glyph: slot then eight rows, top first
// - cursor column 0..15, row 0..1, auto-advance
// - host handles line ends, no wrap
// - lcd init: 8-bit, two lines, 5x10, clear, backlight
// - clear erases and homes cursor; expander only homes it, clear bit reaches no output
// - code zero shows user glyph
// - backlight switch independent of contents
// - host inits link before lcd commands
// - direction bit set means output
// - switch register returns dip switches
package sbio_pkg;
    // address byte: bit 7 = read, bits 6:0 register select
    localparam int unsigned ADDR_READ_BIT = 7;
    localparam logic [6:0] REG_SWITCH = 7'h00;
    localparam logic [6:0] REG_LED = 7'h01;
    localparam logic [6:0] REG_DATA0 = 7'h04;
    localparam logic [6:0] REG_DIR0 = 7'h08;
    localparam logic [6:0] REG_LCD_CTRL = 7'h0C;
    localparam logic [6:0] REG_LCD_POS = 7'h0D;
    localparam logic [6:0] REG_LCD_CHAR = 7'h0E;
    localparam logic [6:0] REG_GLYPH_SEL = 7'h0F;
    localparam logic [6:0] REG_GLYPH_ROW = 7'h10;
    localparam int unsigned BANKS = 3;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] LED_RESET = 8'h00;
    // lcd control bits
    localparam int unsigned CTRL_BACKLIGHT = 0;
    localparam int unsigned CTRL_DISPLAY = 1;
    localparam int unsigned CTRL_CLEAR = 2;
    localparam int unsigned CTRL_BUS8 = 3;
    localparam int unsigned CTRL_TWOLINE = 4;
    localparam int unsigned CTRL_TALLFONT = 5;
    localparam int unsigned COLUMNS = 16;
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned LINK_RATE_HZ = 1000000;
    localparam int unsigned CLOCK_HZ = 200000000;
    // half period of the serial clock in host clocks
    localparam int unsigned HALF_BIT_CYC = CLOCK_HZ / LINK_RATE_HZ / 2;
    localparam int unsigned CS_GAP_CYC = 2 * HALF_BIT_CYC;
endpackage

// >>> design/sbio_link_if.sv
`timescale 1ns/1ps
// Purpose: serial link between host master and expander slave
// Assumes: selN active low, sample on rising sclk
// Notes: misoOe is high while the expander drives miso
interface sbio_link_if;
    logic sclk;
    logic selN;
    logic mosi;
    logic miso;
    logic misoOe;
    modport host (output sclk, output selN, output mosi, input miso);
    modport dev (input sclk, input selN, input mosi, output miso,
        output misoOe);
endinterface

// >>> design/sbio_expander.sv
`timescale 1ns/1ps
// Purpose: expander slave: gpio banks, leds, switches, lcd state
// Assumes: logic clocked by the link clock sclk; selN frames a transfer
// Notes: pins and switches are sampled through two flops on sclk
module sbio_expander (
    input wire logic resetn,
    sbio_link_if.dev link,
    input wire logic [23:0] gpioIn,
    output logic [23:0] gpioOut,
    output logic [23:0] gpioOe,
    input wire logic [7:0] dipSwitch,
    output logic [7:0] ledPattern,
    output logic backlight,
    output logic displayOn,
    output logic [2:0] lcdMode,
    output logic [3:0] cursorColumn,
    output logic cursorRow,
    output logic charWe,
    output logic [7:0] charCode,
    output logic glyphWe,
    output logic [2:0] glyphSlot,
    output logic [2:0] glyphRow,
    output logic [7:0] glyphBits
);
    // ========================================
    // input synchronisers
    logic [23:0] pinMeta_r, pinSync_r;
    logic [7:0] dipMeta_r, dipSync_r;
    always_ff @(posedge link.sclk or negedge resetn) begin
        if (!resetn) begin
            pinMeta_r <= 24'h000000;
            pinSync_r <= 24'h000000;
            dipMeta_r <= 8'h00;
            dipSync_r <= 8'h00;
        end else begin
            pinMeta_r <= gpioIn;
            pinSync_r <= pinMeta_r;
            dipMeta_r <= dipSwitch;
            dipSync_r <= dipMeta_r;
        end
    end

    // ========================================
    // shifter: frame of address byte then data byte
    logic [3:0] bitCnt_r;
    logic [14:0] shift_r;
    logic [7:0] txByte_r;
    logic [7:0] dataReg_r [sbio_pkg::BANKS];
    logic [7:0] dirReg_r [sbio_pkg::BANKS];
    logic [7:0] led_r;
    logic [5:0] ctrl_r;
    logic [3:0] col_r;
    logic row_r;
    logic [2:0] gSlot_r, gRow_r;
    logic chStb_r, glStb_r;
    logic [7:0] wrData_r;

    wire lastBit = (bitCnt_r == 4'(sbio_pkg::FRAME_BITS - 1));
    wire addrDone = (bitCnt_r == 4'h7);
    wire [7:0] fullData = {shift_r[6:0], link.mosi};

    function automatic logic [7:0] read_mux(input logic [6:0] sel);
        logic [7:0] v;
        v = 8'h00;
        if (sel == sbio_pkg::REG_SWITCH) v = dipSync_r;
        if (sel == sbio_pkg::REG_LED) v = led_r;
        for (int b = 0; b < sbio_pkg::BANKS; b++) begin
            if (sel == sbio_pkg::REG_DATA0 + 7'(b))
                v = (dataReg_r[b] & dirReg_r[b])
                    | (pinSync_r[8*b +: 8] & ~dirReg_r[b]);
            if (sel == sbio_pkg::REG_DIR0 + 7'(b)) v = dirReg_r[b];
        end
        if (sel == sbio_pkg::REG_LCD_CTRL) v = {2'b00, ctrl_r};
        if (sel == sbio_pkg::REG_LCD_POS) v = {3'b000, row_r, col_r};
        if (sel == sbio_pkg::REG_GLYPH_SEL) v = {2'b00, gRow_r, gSlot_r};
        return v;
    endfunction

    // address byte kept through the data phase of the frame
    logic [7:0] addrHold_r;

    // sclk is still outside frames, so a rising select clears the count;
    // a cut frame then cannot skew the next one
    always_ff @(posedge link.sclk or negedge resetn
        or posedge link.selN) begin
        if (!resetn) begin
            bitCnt_r <= 4'h0;
        end else if (link.selN) begin
            bitCnt_r <= 4'h0;
        end else begin
            bitCnt_r <= bitCnt_r + 4'h1;
        end
    end

    always_ff @(posedge link.sclk or negedge resetn) begin
        if (!resetn) begin
            shift_r <= 15'h0000;
            addrHold_r <= 8'h00;
        end else if (!link.selN) begin
            shift_r <= {shift_r[13:0], link.mosi};
            if (addrDone)
                addrHold_r <= {shift_r[6:0], link.mosi};
        end
    end

    wire [6:0] heldSel = addrHold_r[6:0];
    wire heldRead = addrHold_r[sbio_pkg::ADDR_READ_BIT];
    wire dataWr = !link.selN && lastBit && !heldRead;

    // ========================================
    // read data: loaded after the address byte, shifted on falling sclk
    always_ff @(negedge link.sclk or negedge resetn) begin
        if (!resetn) begin
            txByte_r <= 8'h00;
        end else if (bitCnt_r == 4'h8) begin
            txByte_r <= read_mux(addrHold_r[6:0]);
        end else begin
            txByte_r <= {txByte_r[6:0], 1'b0};
        end
    end
    assign link.miso = txByte_r[7];
    assign link.misoOe = !link.selN && heldRead && bitCnt_r >= 4'h8;

    // ========================================
    // register writes
    always_ff @(posedge link.sclk or negedge resetn) begin
        if (!resetn) begin
            for (int b = 0; b < sbio_pkg::BANKS; b++) begin
                dataReg_r[b] <= 8'h00;
                dirReg_r[b] <= sbio_pkg::DIR_RESET;
            end
            led_r <= sbio_pkg::LED_RESET;
            ctrl_r <= 6'h00;
            col_r <= 4'h0;
            row_r <= 1'b0;
            gSlot_r <= 3'h0;
            gRow_r <= 3'h0;
            chStb_r <= 1'b0;
            glStb_r <= 1'b0;
            wrData_r <= 8'h00;
        end else begin
            chStb_r <= 1'b0;
            glStb_r <= 1'b0;
            ctrl_r[sbio_pkg::CTRL_CLEAR] <= 1'b0;
            if (dataWr) begin
                wrData_r <= fullData;
                for (int b = 0; b < sbio_pkg::BANKS; b++) begin
                    if (heldSel == sbio_pkg::REG_DATA0 + 7'(b))
                        dataReg_r[b] <= fullData;
                    if (heldSel == sbio_pkg::REG_DIR0 + 7'(b))
                        dirReg_r[b] <= fullData;
                end
                if (heldSel == sbio_pkg::REG_LED) led_r <= fullData;
                if (heldSel == sbio_pkg::REG_LCD_CTRL) begin
                    ctrl_r <= fullData[5:0];
                    if (fullData[sbio_pkg::CTRL_CLEAR]) begin
                        col_r <= 4'h0;
                        row_r <= 1'b0;
                    end
                end
                if (heldSel == sbio_pkg::REG_LCD_POS) begin
                    col_r <= fullData[3:0];
                    row_r <= fullData[4];
                end
                if (heldSel == sbio_pkg::REG_LCD_CHAR) begin
                    // any code, zero included, is placed; no row wrap
                    chStb_r <= 1'b1;
                    if (col_r != 4'(sbio_pkg::COLUMNS - 1))
                        col_r <= col_r + 4'h1;
                end
                if (heldSel == sbio_pkg::REG_GLYPH_SEL) begin
                    gSlot_r <= fullData[2:0];
                    gRow_r <= 3'h0;
                end
                if (heldSel == sbio_pkg::REG_GLYPH_ROW) begin
                    glStb_r <= 1'b1;
                    gRow_r <= gRow_r + 3'h1;
                end
            end
        end
    end

    // ========================================
    // outputs
    logic [3:0] chCol_r;
    logic chRow_r;
    logic [2:0] glRow_r;
    always_ff @(posedge link.sclk or negedge resetn) begin
        if (!resetn) begin
            chCol_r <= 4'h0;
            chRow_r <= 1'b0;
            glRow_r <= 3'h0;
        end else if (dataWr) begin
            chCol_r <= col_r;
            chRow_r <= row_r;
            glRow_r <= gRow_r;
        end
    end

    for (genvar b = 0; b < sbio_pkg::BANKS; b++) begin : g_bank
        assign gpioOut[8*b +: 8] = dataReg_r[b] & dirReg_r[b];
        assign gpioOe[8*b +: 8] = dirReg_r[b];
    end
    assign ledPattern = led_r;
    assign backlight = ctrl_r[sbio_pkg::CTRL_BACKLIGHT];
    assign displayOn = ctrl_r[sbio_pkg::CTRL_DISPLAY];
    assign lcdMode = {ctrl_r[sbio_pkg::CTRL_TALLFONT],
        ctrl_r[sbio_pkg::CTRL_TWOLINE], ctrl_r[sbio_pkg::CTRL_BUS8]};
    assign cursorColumn = chStb_r ? chCol_r : col_r;
    assign cursorRow = chStb_r ? chRow_r : row_r;
    assign charWe = chStb_r;
    assign charCode = wrData_r;
    assign glyphWe = glStb_r;
    assign glyphSlot = gSlot_r;
    assign glyphRow = glRow_r;
    assign glyphBits = wrData_r;
endmodule

// >>> design/sbio_host.sv
`timescale 1ns/1ps
// Purpose: host master end: one register access per request
// Assumes: sclk divided from clock; mode 0; miso sampled via two flops
// Notes: reqReady high when idle; rdValid pulses with read data
module sbio_host (
    input wire logic clock,
    input wire logic resetn,
    sbio_link_if.host link,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqRead,
    input wire logic [6:0] reqSel,
    input wire logic [7:0] reqData,
    output logic rdValid,
    output logic [7:0] rdData
);
    typedef enum logic [1:0] {
        SBIO_IDLE = 2'b00,
        SBIO_SHIFT = 2'b01,
        SBIO_GAP = 2'b11
    } sbio_state_t;

    localparam int unsigned HALF = sbio_pkg::HALF_BIT_CYC;

    sbio_state_t state_r;
    logic [7:0] divCnt_r;
    logic [4:0] edgeCnt_r;
    logic [15:0] txShift_r;
    logic [7:0] rxShift_r;
    logic sclk_r, sel_r, read_r, rdValid_r;
    logic [7:0] rdData_r;
    logic misoMeta_r, misoSync_r;

    wire halfDone = (divCnt_r == 8'(HALF - 1));
    wire lastEdge = (edgeCnt_r == 5'(2 * sbio_pkg::FRAME_BITS - 1));

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            misoMeta_r <= 1'b0;
            misoSync_r <= 1'b0;
        end else begin
            misoMeta_r <= link.miso;
            misoSync_r <= misoMeta_r;
        end
    end

    // ========================================
    // transfer sequencer
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= SBIO_IDLE;
            divCnt_r <= 8'h00;
            edgeCnt_r <= 5'h00;
            txShift_r <= 16'h0000;
            rxShift_r <= 8'h00;
            sclk_r <= 1'b0;
            sel_r <= 1'b0;
            read_r <= 1'b0;
            rdValid_r <= 1'b0;
            rdData_r <= 8'h00;
        end else begin
            rdValid_r <= 1'b0;
            unique case (state_r)
                SBIO_IDLE: begin
                    divCnt_r <= 8'h00;
                    if (reqValid) begin
                        txShift_r <= {reqRead, reqSel,
                            reqRead ? 8'h00 : reqData};
                        read_r <= reqRead;
                        sel_r <= 1'b1;
                        edgeCnt_r <= 5'h00;
                        state_r <= SBIO_SHIFT;
                    end
                end
                SBIO_SHIFT: begin
                    divCnt_r <= halfDone ? 8'h00 : divCnt_r + 8'h01;
                    if (halfDone) begin
                        sclk_r <= !sclk_r;
                        edgeCnt_r <= edgeCnt_r + 5'h01;
                        if (sclk_r)
                            txShift_r <= {txShift_r[14:0], 1'b0};
                        else
                            rxShift_r <= {rxShift_r[6:0], misoSync_r};
                        if (lastEdge) begin
                            state_r <= SBIO_GAP;
                            sel_r <= 1'b0;
                            rdData_r <= rxShift_r;
                            rdValid_r <= read_r;
                        end
                    end
                end
                SBIO_GAP: begin
                    divCnt_r <= divCnt_r + 8'h01;
                    if (divCnt_r == 8'(sbio_pkg::CS_GAP_CYC - 1))
                        state_r <= SBIO_IDLE;
                end
                default: state_r <= SBIO_IDLE;
            endcase
        end
    end

    assign link.sclk = sclk_r;
    assign link.selN = !sel_r;
    assign link.mosi = txShift_r[15];
    assign reqReady = (state_r == SBIO_IDLE);
    assign rdValid = rdValid_r;
    assign rdData = rdData_r;
endmodule

// >>> verification/sbio_link_props.sv
`timescale 1ns/1ps
// Purpose: link-level checks between host master and expander slave
// Assumes: all checks sampled on the host clock
// Notes: sclk is a divided clock, so it is watched as data here
module sbio_link_props (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic selN,
    input wire logic mosi,
    input wire logic miso,
    input wire logic misoOe,
    input wire logic reqReady,
    input wire logic rdValid
);
    // ==========================================================
    // helper logic
    localparam int HALFM1 = sbio_pkg::HALF_BIT_CYC - 1;
    localparam int GAPM1 = sbio_pkg::CS_GAP_CYC - 1;
    logic sclkD_r;
    logic [5:0] riseCnt_r;

    // counts rising sclk edges inside one frame
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sclkD_r <= 1'b0;
            riseCnt_r <= 6'h00;
        end else begin
            sclkD_r <= sclk;
            if (selN)
                riseCnt_r <= 6'h00;
            else if (sclk && !sclkD_r)
                riseCnt_r <= riseCnt_r + 6'h01;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    AST_SCLK_IDLE: assert property (selN |-> !sclk)
        else $error("sclk not low outside frame");
    AST_SCLK_HALF: assert property (
        $rose(sclk) |-> ##HALFM1 sclk ##1 !sclk)
        else $error("sclk high phase wrong length");
    AST_FRAME_LEN: assert property (
        $rose(selN) |-> riseCnt_r == 6'h10)
        else $error("frame is not sixteen bits");
    AST_GAP: assert property ($rose(selN) |-> ##GAPM1 selN)
        else $error("select gap too short");
    AST_MOSI_EDGE: assert property (
        !selN && !$past(selN) && $changed(mosi) |-> !sclk)
        else $error("mosi moved while sclk high");
    AST_MISO_EDGE: assert property (
        !selN && !$past(selN) && $changed(miso) |-> !sclk)
        else $error("miso moved while sclk high");
    // first seven address bits of a frame and idle time: the expander must not drive
    AST_MISO_OE: assert property (riseCnt_r < 6'h07 |-> !misoOe)
        else $error("miso driven outside read data phase");
    AST_RD_AFTER: assert property (
        rdValid |-> selN && !$past(rdValid))
        else $error("read data not a single pulse after frame");
    AST_READY_BUSY: assert property (!selN |-> !reqReady)
        else $error("host ready during frame");
endmodule

// >>> verification/spi_board_io_expander_bench.sv
`timescale 1ns/1ps
// Purpose: host and expander joined over the link, driven from user side
// Assumes: each access costs one frame plus the select gap
// Notes: char and glyph strobes are logged from the host clock
module spi_board_io_expander_bench;
    // ==========================================================
    // signals
    localparam int LIMIT = 99000;
    logic clock = 1'b0;
    logic resetn = 1'b1;
    logic reqValid = 1'b0;
    logic reqRead = 1'b0;
    logic [6:0] reqSel = 7'h00;
    logic [7:0] reqData = 8'h00;
    logic [23:0] gpioIn = 24'hC3550F;
    logic [7:0] dipSwitch = 8'h96;
    logic reqReady, rdValid, backlight, displayOn, cursorRow;
    logic charWe, glyphWe, chD, glD;
    logic [7:0] rdData, ledPattern, charCode, glyphBits;
    logic [23:0] gpioOut, gpioOe;
    logic [2:0] lcdMode, glyphSlot, glyphRow;
    logic [3:0] cursorColumn;
    logic [12:0] chLog [8];
    logic [13:0] glLog [8];
    int chN = 0;
    int glN = 0;
    int cyc = 0;
    int error_cnt = 0;
    int samples_checked = 0;

    sbio_link_if lnk();
    sbio_expander i_sbio_expander (.resetn(resetn), .link(lnk),
        .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
        .dipSwitch(dipSwitch), .ledPattern(ledPattern),
        .backlight(backlight), .displayOn(displayOn), .lcdMode(lcdMode),
        .cursorColumn(cursorColumn), .cursorRow(cursorRow),
        .charWe(charWe), .charCode(charCode), .glyphWe(glyphWe),
        .glyphSlot(glyphSlot), .glyphRow(glyphRow), .glyphBits(glyphBits));
    sbio_host i_sbio_host (.clock(clock), .resetn(resetn), .link(lnk),
        .reqValid(reqValid), .reqReady(reqReady), .reqRead(reqRead),
        .reqSel(reqSel), .reqData(reqData), .rdValid(rdValid),
        .rdData(rdData));
    sbio_link_props i_sbio_link_props (.clock(clock), .resetn(resetn),
        .sclk(lnk.sclk), .selN(lnk.selN), .mosi(lnk.mosi), .miso(lnk.miso),
        .misoOe(lnk.misoOe), .reqReady(reqReady), .rdValid(rdValid));

    always #2.5 clock = ~clock;

    // strobes hold until the first sclk rise of the next frame, so a rise is always seen
    always @(posedge clock) begin
        chD <= charWe;
        glD <= glyphWe;
        if (charWe === 1'b1 && chD !== 1'b1 && chN < 8) begin
            chLog[chN] <= {cursorRow, cursorColumn, charCode};
            chN <= chN + 1;
        end
        if (glyphWe === 1'b1 && glD !== 1'b1 && glN < 8) begin
            glLog[glN] <= {glyphSlot, glyphRow, glyphBits};
            glN <= glN + 1;
        end
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt = error_cnt + 1;
            summarize();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // returns only once the host is idle again, gap included
    task automatic xfer(input logic rd, input logic [6:0] sel,
        input logic [7:0] d, output logic [7:0] got);
        logic rdy;
        got = 8'h00;
        @(posedge clock);
        #1;
        reqValid = 1'b1;
        reqRead = rd;
        reqSel = sel;
        reqData = d;
        rdy = 1'b0;
        while (!rdy) begin
            rdy = (reqReady === 1'b1);
            @(posedge clock);
            #1;
        end
        reqValid = 1'b0;
        rdy = 1'b0;
        while (!rdy) begin
            @(posedge clock);
            #1;
            if (rdValid === 1'b1)
                got = rdData;
            rdy = (reqReady === 1'b1);
        end
    endtask

    task automatic wr(input logic [6:0] sel, input logic [7:0] d);
        logic [7:0] g;
        xfer(1'b0, sel, d, g);
    endtask

    task automatic rdchk(input logic [6:0] sel, input logic [7:0] e);
        logic [7:0] g;
        xfer(1'b1, sel, 8'h00, g);
        check(24'(g), 24'(e));
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        check(gpioOe, 24'h000000);
        check(24'(ledPattern), 24'(sbio_pkg::LED_RESET));
        rdchk(sbio_pkg::REG_DIR0 + 7'h02, sbio_pkg::DIR_RESET);
        rdchk(sbio_pkg::REG_LED, sbio_pkg::LED_RESET);
        rdchk(sbio_pkg::REG_SWITCH, 8'h96);
        $display("test reset done");
    endtask

    task automatic t_led();
        wr(sbio_pkg::REG_LED, 8'hA5);
        check(24'(ledPattern), 24'h0000A5);
        rdchk(sbio_pkg::REG_LED, 8'hA5);
        $display("test led done");
    endtask

    task automatic t_gpio();
        wr(sbio_pkg::REG_DIR0 + 7'h01, 8'hF0);
        wr(sbio_pkg::REG_DATA0 + 7'h01, 8'h3C);
        check(gpioOe, 24'h00F000);
        check(gpioOut, 24'h003000);
        rdchk(sbio_pkg::REG_DATA0 + 7'h01, 8'h35);
        rdchk(sbio_pkg::REG_DIR0 + 7'h01, 8'hF0);
        rdchk(sbio_pkg::REG_DATA0, 8'h0F);
        $display("test gpio done");
    endtask

    // leds and directions were set by earlier tests; reset must drop them
    task automatic t_midreset();
        @(posedge clock);
        #1 resetn = 1'b0;
        repeat (2) @(posedge clock);
        #1 resetn = 1'b1;
        check(gpioOe, 24'h000000);
        check(24'(ledPattern), 24'(sbio_pkg::LED_RESET));
        rdchk(sbio_pkg::REG_DATA0 + 7'h01, 8'h55);
        $display("test mid-run reset done");
    endtask

    task automatic t_lcd();
        wr(sbio_pkg::REG_LCD_CTRL, 8'h3B);
        check(24'({lcdMode, displayOn, backlight}), 24'h00001F);
        wr(sbio_pkg::REG_LCD_POS, 8'h1E);
        wr(sbio_pkg::REG_LCD_CHAR, 8'h00);
        wr(sbio_pkg::REG_LCD_CHAR, 8'h41);
        wr(sbio_pkg::REG_LCD_CHAR, 8'h42);
        wr(sbio_pkg::REG_LCD_CTRL, 8'h3F);
        check(24'(chN), 24'h000003);
        check(24'(chLog[0]), 24'h001E00);
        check(24'(chLog[1]), 24'h001F41);
        check(24'(chLog[2]), 24'h001F42);
        wr(sbio_pkg::REG_LCD_CTRL, 8'h3A);
        check(24'({cursorRow, cursorColumn}), 24'h000000);
        check(24'({displayOn, backlight}), 24'h000002);
        $display("test lcd done");
    endtask

    task automatic t_glyph();
        wr(sbio_pkg::REG_GLYPH_SEL, 8'h05);
        for (int i = 0; i < 8; i++)
            wr(sbio_pkg::REG_GLYPH_ROW, 8'(i * 37 + 1));
        rdchk(7'h7F, 8'h00);
        check(24'(glN), 24'h000008);
        for (int i = 0; i < 8; i++)
            check(24'(glLog[i]), 24'({3'h5, 3'(i), 8'(i * 37 + 1)}));
        $display("test glyph done");
    endtask

    // ==========================================================
    // run
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        // a real falling edge, so the sclk-clocked end resets too
        #1 resetn = 1'b0;
        repeat (20) @(posedge clock);
        #1 resetn = 1'b1;
        t_reset();
        t_led();
        t_gpio();
        t_midreset();
        t_lcd();
        t_glyph();
        summarize();
    end
endmodule
